// File: pad_pkg.sv
// Purpose: Shared constants for the page attribute decoder.
// Assumes: 32-bit descriptors, word-aligned AHB-Lite register map.
// Notes: Offsets are byte addresses.
package pad_pkg;
    localparam logic [1:0] PAD_L1_FAULT = 2'h0;
    localparam logic [1:0] PAD_L1_COARSE = 2'h1;
    localparam logic [1:0] PAD_L1_SECTION = 2'h2;
    localparam logic [1:0] PAD_L1_FINE = 2'h3;
    localparam logic [1:0] PAD_L2_FAULT = 2'h0;
    localparam logic [1:0] PAD_L2_LARGE = 2'h1;
    localparam logic [1:0] PAD_L2_SMALL = 2'h2;
    localparam logic [1:0] PAD_L2_EXT = 2'h3;
    localparam int PAD_P_BIT = 9;
    localparam int PAD_DOM_LSB = 5;
    localparam int PAD_SEC_TEX_LSB = 12;
    localparam int PAD_SEC_AP_LSB = 10;
    localparam int PAD_LARGE_TEX_LSB = 12;
    localparam int PAD_EXT_TEX_LSB = 6;
    localparam int PAD_EXT_AP_LSB = 4;
    localparam int PAD_C_BIT = 3;
    localparam int PAD_B_BIT = 2;
    localparam int PAD_PAGE_AP_LSB = 4;
    localparam int PAD_SCTL_ECC_WALK_BIT = 1;
    localparam logic [7:0] PAD_OFF_CTRL = 8'h00;
    localparam logic [7:0] PAD_OFF_L1 = 8'h04;
    localparam logic [7:0] PAD_OFF_L2 = 8'h08;
    localparam logic [7:0] PAD_OFF_RESULT = 8'h0c;
    localparam logic [31:0] PAD_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PAD_DESC_RESET = 32'h0000_0000;
    // Control bits: [1] ecc on walks, [8] bus controller ecc mode; [9] second level fine is never read, the first level type selects fine tables
    localparam int PAD_CTRL_BCU_ECC_BIT = 8;
    localparam int PAD_CTRL_FINE_BIT = 9;
    // Result fields
    localparam int PAD_R_FAULT = 0;
    localparam int PAD_R_CACHE = 1;
    localparam int PAD_R_BUFFER = 2;
    localparam int PAD_R_WT = 3;
    localparam int PAD_R_WALLOC = 4;
    localparam int PAD_R_MINI = 5;
    localparam int PAD_R_ECC = 6;
    localparam int PAD_R_ECC_WALK = 7;
    localparam int PAD_R_XBIT = 8;
    localparam int PAD_R_AP_LSB = 12;
    localparam int PAD_R_DOM_LSB = 16;
    localparam int PAD_R_L2_LSB = 24;
    localparam int PAD_R_L1_LSB = 26;
endpackage

// File: pad_top.sv
// Purpose: Decode table descriptors into memory attributes and policies.
// Assumes: AHB-Lite single word transfers; pin inputs synchronous to hclk.
// Notes: Attributes drive a cache and bus controller through registered outputs.
//
// Overview of operation
// - The extension bit joins cacheable and bufferable as a third bit and, when one, adds four encodings.
// - With the extension bit zero, cacheable and bufferable keep their standard meanings.
// - The old mini-cache encoding now means write-through, and mini-cache moves under the extension bit.
// - Extension encodings include one for the mini-cache and one for write-allocate caching.
// - With write-allocate on a cacheable page, a store miss starts a line fill.
// - Without write-allocate, only a cacheable load miss starts a line fill.
// - Write-through pages send every store to external memory.
// - Page protection plus bus controller ECC mode gives ECC on writes and checks on reads.
// - Control bit 1 applies ECC to page table walk accesses.
// - Only the low bit of the type extension field is used; the rest is ignored.
// - Small pages act as if the extension bit were zero.
// - First level type comes from the two low bits; non-fault forms carry protection and domain.
// - Coarse second level decodes fault, large, small and extended small pages.
// - Fine second level decodes fault, large, small and tiny pages.
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module pad_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic access_valid,
    input wire logic access_store,
    input wire logic access_hit,
    input wire logic walk_access,
    output logic xlate_fault,
    output logic attr_cacheable,
    output logic attr_bufferable,
    output logic attr_write_through,
    output logic attr_mini_cache,
    output logic ecc_enable,
    output logic line_fill,
    output logic ext_store
);
    import pad_pkg::*;

    logic [31:0] ctrl_reg;
    logic [31:0] l1_reg;
    logic [31:0] l2_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] result;
    logic [1:0] l1_type;
    logic [1:0] l2_type;
    logic use_l2;
    logic x_bit;
    logic c_bit;
    logic b_bit;
    logic fault;
    logic [1:0] ap;
    logic [3:0] dom;
    logic prot;
    logic a_cache, a_buf, a_wt, a_walloc, a_mini;
    logic walk_ecc;
    logic page_ecc;

    // Bus slave: zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (clk_en && hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= PAD_CTRL_RESET;
            l1_reg <= PAD_DESC_RESET;
            l2_reg <= PAD_DESC_RESET;
        end else if (clk_en && wr_pend_reg) begin
            unique case (wr_addr_reg)
                PAD_OFF_CTRL: ctrl_reg <= hwdata;
                PAD_OFF_L1: l1_reg <= hwdata;
                PAD_OFF_L2: l2_reg <= hwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                PAD_OFF_CTRL: hrdata <= ctrl_reg;
                PAD_OFF_L1: hrdata <= l1_reg;
                PAD_OFF_L2: hrdata <= l2_reg;
                PAD_OFF_RESULT: hrdata <= result;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Descriptor decode
    always_comb begin
        l1_type = l1_reg[1:0];
        l2_type = l2_reg[1:0];
        use_l2 = (l1_type == PAD_L1_COARSE) || (l1_type == PAD_L1_FINE);
        fault = (l1_type == PAD_L1_FAULT) || (use_l2 && l2_type == PAD_L2_FAULT);
        prot = (l1_type != PAD_L1_FAULT) && l1_reg[PAD_P_BIT];
        dom = l1_reg[PAD_DOM_LSB +: 4];
        x_bit = 1'b0;
        c_bit = 1'b0;
        b_bit = 1'b0;
        ap = 2'h0;
        if (l1_type == PAD_L1_SECTION) begin
            x_bit = l1_reg[PAD_SEC_TEX_LSB];
            c_bit = l1_reg[PAD_C_BIT];
            b_bit = l1_reg[PAD_B_BIT];
            ap = l1_reg[PAD_SEC_AP_LSB +: 2];
        end else if (use_l2) begin
            c_bit = l2_reg[PAD_C_BIT];
            b_bit = l2_reg[PAD_B_BIT];
            unique case (l2_type)
                PAD_L2_LARGE: begin
                    x_bit = l2_reg[PAD_LARGE_TEX_LSB];
                    ap = l2_reg[PAD_PAGE_AP_LSB +: 2];
                end
                PAD_L2_SMALL: begin
                    x_bit = 1'b0;
                    ap = l2_reg[PAD_PAGE_AP_LSB +: 2];
                end
                // Extended small in coarse tables, tiny in fine tables: same layout
                PAD_L2_EXT: begin
                    x_bit = l2_reg[PAD_EXT_TEX_LSB];
                    ap = l2_reg[PAD_EXT_AP_LSB +: 2];
                end
                default: begin
                    x_bit = 1'b0;
                    ap = 2'h0;
                end
            endcase
        end
        a_cache = 1'b0;
        a_buf = 1'b0;
        a_wt = 1'b0;
        a_walloc = 1'b0;
        a_mini = 1'b0;
        if (!fault) begin
            unique case ({x_bit, c_bit, b_bit})
                3'h0: ;
                3'h1: a_buf = 1'b1;
                3'h2: begin
                    a_cache = 1'b1;
                    a_wt = 1'b1;
                end
                3'h3: begin
                    a_cache = 1'b1;
                    a_buf = 1'b1;
                end
                3'h4: ;
                3'h5: a_buf = 1'b1;
                3'h6: begin
                    a_cache = 1'b1;
                    a_mini = 1'b1;
                end
                3'h7: begin
                    a_cache = 1'b1;
                    a_buf = 1'b1;
                    a_walloc = 1'b1;
                end
                default: ;
            endcase
        end
        page_ecc = !fault && prot && ctrl_reg[PAD_CTRL_BCU_ECC_BIT];
        walk_ecc = ctrl_reg[PAD_SCTL_ECC_WALK_BIT];
        result = 32'h0000_0000;
        result[PAD_R_FAULT] = fault;
        result[PAD_R_CACHE] = a_cache;
        result[PAD_R_BUFFER] = a_buf;
        result[PAD_R_WT] = a_wt;
        result[PAD_R_WALLOC] = a_walloc;
        result[PAD_R_MINI] = a_mini;
        result[PAD_R_ECC] = page_ecc;
        result[PAD_R_ECC_WALK] = walk_ecc;
        result[PAD_R_XBIT] = x_bit;
        result[PAD_R_AP_LSB +: 2] = ap;
        result[PAD_R_DOM_LSB +: 4] = fault ? 4'h0 : dom;
        result[PAD_R_L2_LSB +: 2] = l2_type;
        result[PAD_R_L1_LSB +: 2] = l1_type;
    end

    // Attribute outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xlate_fault <= 1'b0;
            attr_cacheable <= 1'b0;
            attr_bufferable <= 1'b0;
            attr_write_through <= 1'b0;
            attr_mini_cache <= 1'b0;
        end else if (clk_en) begin
            xlate_fault <= fault;
            attr_cacheable <= a_cache;
            attr_bufferable <= a_buf;
            attr_write_through <= a_wt;
            attr_mini_cache <= a_mini;
        end
    end

    // Access policy: one-cycle results per access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_fill <= 1'b0;
            ext_store <= 1'b0;
            ecc_enable <= 1'b0;
        end else if (clk_en) begin
            line_fill <= access_valid && !walk_access && a_cache && !access_hit &&
                         (!access_store || a_walloc);
            ext_store <= access_valid && !walk_access && access_store && !fault &&
                         (a_wt || !a_cache || !access_hit || !a_buf);
            ecc_enable <= access_valid && (walk_access ? walk_ecc : page_ecc);
        end
    end

    chk_store_wa_fill: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && !walk_access && access_store && !access_hit && a_cache && a_walloc
        |=> line_fill)
        else $error("store miss with write-allocate did not fill");
    chk_store_no_fill: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && access_store && !a_walloc |=> !line_fill)
        else $error("store miss filled without write-allocate");
    chk_load_fill: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && !walk_access && !access_store && !access_hit && a_cache |=> line_fill)
        else $error("cacheable load miss did not fill");
    chk_wt_store: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && !walk_access && access_store && a_wt |=> ext_store)
        else $error("write-through store not sent out");
    chk_fault_noattr: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && l1_type == PAD_L1_FAULT |=> xlate_fault && !attr_cacheable && !attr_bufferable)
        else $error("fault descriptor produced attributes");
    chk_small_nox: assert property (@(posedge hclk) disable iff (!hresetn)
        use_l2 && l2_type == PAD_L2_SMALL |-> !x_bit)
        else $error("small page used extension bit");
    chk_xbit_only: assert property (@(posedge hclk) disable iff (!hresetn)
        l1_type == PAD_L1_SECTION |-> x_bit == l1_reg[PAD_SEC_TEX_LSB])
        else $error("extension bit not taken from field low bit");
    chk_wt_encode: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !fault && !x_bit && c_bit && !b_bit |=> attr_write_through && !attr_mini_cache)
        else $error("cached unbuffered page not write-through");
    chk_mini_encode: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !fault && x_bit && c_bit && !b_bit |=> attr_mini_cache)
        else $error("mini-cache encoding not decoded");
    chk_walk_ecc: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && walk_access |=> ecc_enable == $past(ctrl_reg[PAD_SCTL_ECC_WALK_BIT]))
        else $error("walk ecc does not follow control bit");
    chk_page_ecc_on: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && !walk_access && !fault && prot && ctrl_reg[PAD_CTRL_BCU_ECC_BIT] |=> ecc_enable)
        else $error("protected page access without ecc");
    chk_page_ecc_off: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && !walk_access && !prot |=> !ecc_enable)
        else $error("unprotected page access used ecc");
    chk_std_wback: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !fault && !x_bit && c_bit && b_bit |=> attr_cacheable && attr_bufferable && !attr_write_through)
        else $error("standard write-back encoding misdecoded");
    chk_std_uncached: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !fault && !x_bit && !c_bit |=> !attr_cacheable && !attr_write_through && !attr_mini_cache)
        else $error("standard uncached encoding produced caching");
    chk_std_buffer: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !fault && !x_bit && b_bit |=> attr_bufferable)
        else $error("standard bufferable bit lost");
    chk_x_uncached: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !fault && x_bit && !c_bit && !b_bit |=> !attr_cacheable && !attr_bufferable)
        else $error("extended uncached encoding misdecoded");
    chk_wa_result: assert property (@(posedge hclk) disable iff (!hresetn)
        !fault && x_bit && c_bit && b_bit |-> result[PAD_R_WALLOC])
        else $error("write-allocate encoding not decoded");
    chk_fault_noext: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && fault |=> !ext_store && !line_fill)
        else $error("fault page produced memory traffic");
    chk_l2_fault: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && use_l2 && l2_type == PAD_L2_FAULT |=> xlate_fault)
        else $error("second level fault not reported");
    chk_ext_xbit: assert property (@(posedge hclk) disable iff (!hresetn)
        use_l2 && l2_type == PAD_L2_EXT |-> x_bit == l2_reg[PAD_EXT_TEX_LSB])
        else $error("extended page extension bit misplaced");
    chk_hit_nofill: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && access_valid && access_hit |=> !line_fill)
        else $error("cache hit started a line fill");
endmodule

// File: pad_cache_model.sv
// Purpose: Far-side model of the data cache and memory path issuing accesses.
// Assumes: One access per call; the decoder answers one cycle after taking it.
// Notes: Qualifiers are inverted once released so a stale value never passes.
`timescale 1ns/1ps
module pad_cache_model (
    input wire logic hclk,
    output logic access_valid,
    output logic access_store,
    output logic access_hit,
    output logic walk_access,
    input wire logic line_fill,
    input wire logic ext_store,
    input wire logic ecc_enable
);
    initial begin
        access_valid = 1'b0;
        {access_store, access_hit, walk_access} = 3'h0;
    end

    // sw is {store, hit, walk}; seen is {line_fill, ext_store, ecc_enable}
    task automatic issue(input logic [2:0] sw, output logic [2:0] seen);
        @(posedge hclk);
        access_valid <= 1'b1;
        {access_store, access_hit, walk_access} <= sw;
        @(posedge hclk);
        access_valid <= 1'b0;
        {access_store, access_hit, walk_access} <= ~sw;
        #1 seen = {line_fill, ext_store, ecc_enable};
    endtask
endmodule

// File: testbench.sv
// Purpose: Self-checking bench for the page attribute decoder.
// Assumes: Zero-wait AHB-Lite slave; attributes settle one cycle after a write.
// Notes: Descriptor rows and access rows are table driven; odd cases follow.
`timescale 1ns/1ps
module testbench;
    import pad_pkg::*;
    typedef struct packed {logic [31:0] l1; logic [31:0] l2; logic [6:0] e;} pad_drow_t;
    typedef struct packed {logic [31:0] ctrl; logic [31:0] l1; logic [2:0] sw; logic [2:0] e;} pad_arow_t;
    logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, keep;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, seen;
    logic hreadyout, hresp, access_valid, access_store, access_hit, walk_access, xlate_fault;
    logic attr_cacheable, attr_bufferable, attr_write_through, attr_mini_cache, ecc_enable, line_fill, ext_store;
    int fails = 0, total_checks = 0;
    // e is {bufferable, x, mini, write_alloc, write_through, cacheable, fault}
    pad_drow_t drows [19] = '{'{32'h2, 0, 7'h00}, '{32'h6, 0, 7'h40}, '{32'ha, 0, 7'h06}, '{32'he, 0, 7'h42},
        '{32'h1002, 0, 7'h20}, '{32'h1006, 0, 7'h60}, '{32'h100a, 0, 7'h32}, '{32'h100e, 0, 7'h6a},
        '{32'h700a, 0, 7'h32}, '{32'h600a, 0, 7'h06}, '{32'h1, 32'h1009, 7'h32}, '{32'h1, 32'h100a, 7'h06},
        '{32'h1, 32'h4b, 7'h32}, '{32'h1, 32'hcb, 7'h32}, '{32'h1, 32'h8b, 7'h06}, '{32'h1, 32'h0, 7'h01},
        '{32'h3, 32'h4f, 7'h6a}, '{32'h3, 32'h100a, 7'h06}, '{32'h0, 32'h4f, 7'h01}};
    pad_arow_t arows [12] = '{'{0, 32'h100e, 3'b100, 3'b110}, '{0, 32'he, 3'b100, 3'b010},
        '{0, 32'he, 3'b000, 3'b100}, '{0, 32'he, 3'b110, 3'b000}, '{0, 32'ha, 3'b110, 3'b010},
        '{0, 32'ha, 3'b100, 3'b010}, '{0, 32'h0, 3'b100, 3'b000}, '{32'h100, 32'h202, 3'b000, 3'b001},
        '{0, 32'h202, 3'b000, 3'b000}, '{32'h100, 32'h2, 3'b000, 3'b000}, '{32'h2, 32'he, 3'b001, 3'b001},
        '{0, 32'he, 3'b001, 3'b000}};

    pad_top pad_top_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .access_valid(access_valid), .access_store(access_store),
        .access_hit(access_hit), .walk_access(walk_access), .xlate_fault(xlate_fault),
        .attr_cacheable(attr_cacheable), .attr_bufferable(attr_bufferable),
        .attr_write_through(attr_write_through), .attr_mini_cache(attr_mini_cache), .ecc_enable(ecc_enable),
        .line_fill(line_fill), .ext_store(ext_store));
    pad_cache_model pad_cache_model_i (.hclk(hclk), .access_valid(access_valid), .access_store(access_store),
        .access_hit(access_hit), .walk_access(walk_access), .line_fill(line_fill), .ext_store(ext_store),
        .ecc_enable(ecc_enable));

    always #20 hclk = ~hclk;

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        fails++;
        results();
    end

    initial begin
        repeat (6) @(posedge hclk);
        #1 check({hreadyout, xlate_fault, line_fill, ext_store, hresp}, 5'h10);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        #1 check(xlate_fault, 1'b1);
        ahb(0, PAD_OFF_CTRL, 0, rd); check(rd, PAD_CTRL_RESET);
        ahb(0, PAD_OFF_L2, 0, rd); check(rd, PAD_DESC_RESET);
        foreach (drows[i]) begin
            ahb(1, PAD_OFF_L1, drows[i].l1, rd);
            ahb(1, PAD_OFF_L2, drows[i].l2, rd);
            repeat (2) @(posedge hclk);
            #1 check({attr_mini_cache, attr_write_through, attr_cacheable, xlate_fault},
                {drows[i].e[4], drows[i].e[2], drows[i].e[1], drows[i].e[0]});
            check(attr_bufferable, drows[i].e[6]);
            ahb(0, PAD_OFF_RESULT, 0, rd);
            check({rd[8], rd[5:3], rd[1:0]}, drows[i].e[5:0]);
        end
        foreach (arows[i]) begin
            ahb(1, PAD_OFF_CTRL, arows[i].ctrl, rd);
            ahb(1, PAD_OFF_L1, arows[i].l1, rd);
            repeat (2) @(posedge hclk);
            pad_cache_model_i.issue(arows[i].sw, seen);
            check(seen, arows[i].e);
        end
        // Section fields, read-back, unmapped place and read-only result
        ahb(1, PAD_OFF_L1, 32'hd42, rd);
        ahb(0, PAD_OFF_L1, 0, rd); check(rd, 32'hd42);
        ahb(0, PAD_OFF_RESULT, 0, keep);
        check({keep[27:26], keep[19:16], keep[13:12]}, {PAD_L1_SECTION, 4'ha, 2'h3});
        ahb(1, PAD_OFF_RESULT, 32'hffff_ffff, rd);
        ahb(0, PAD_OFF_RESULT, 0, rd); check(rd, keep);
        ahb(1, 8'h10, 32'hffff_ffff, rd);
        ahb(0, 8'h10, 0, rd); check(rd, 32'h0);
        // Frozen clock enable must swallow an access
        ahb(1, PAD_OFF_L1, 32'he, rd);
        repeat (2) @(posedge hclk);
        clk_en <= 1'b0;
        pad_cache_model_i.issue(3'b000, seen);
        check(seen, 3'b000);
        @(posedge hclk);
        clk_en <= 1'b1;
        pad_cache_model_i.issue(3'b000, seen);
        check(seen, 3'b100);
        results();
    end
endmodule
